// ### trig_port_pkg.sv
// Package with register map, field layout and types of the trigger port control block
package trig_port_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_PORT_CFG = 8'h00;
  localparam logic [7:0] OFS_PULSE_LEN = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_PROBE_PWR = 8'h0c;
  localparam logic [7:0] OFS_OPER_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ****************************************
  // Field positions
  // ****************************************
  // Per-port config: 4 bits per port, port 0 = front, port 1 = rear
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_TYPE_LSB = 1;
  localparam int CFG_LEVEL_BIT = 3;
  localparam int CFG_FIELD_W = 4;
  localparam int OPER_ARMED_BIT = 5;
  localparam int PROBE_SEL_W = 2;

  // Interrupt bits: pulse done per port, then measurement trigger seen
  localparam int IRQ_W = 3;
  localparam int IRQ_MEAS_BIT = 2;

  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [31:0] PULSE_LEN_RST = 32'h0000_0019;
  localparam int CLK_MHZ = 250;
  localparam int EVT_PULSE_NS = 100;
  localparam int EVT_PULSE_CYC = (EVT_PULSE_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OTYPE_DEVICE = 2'h0,
    OTYPE_ARMED = 2'h1,
    OTYPE_USER = 2'h2
  } out_type_t;

  typedef enum logic [1:0] {
    PROBE_OFF = 2'h0,
    PROBE_ONE = 2'h1,
    PROBE_TWO = 2'h2
  } probe_sel_t;

  typedef struct packed {
    logic dir_out;
    out_type_t otype;
    logic idle_high;
  } port_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ### trig_pulse_gen.sv
// Single trigger connector output driver with pulse generator
`timescale 1ns/100ps
module trig_pulse_gen #(
  parameter int CNT_W = 32
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset, active low
  input wire trig_port_pkg::port_cfg_t cfg, // Connector configuration
  input wire logic [CNT_W-1:0] pulse_len, // User pulse width in cycles
  input wire logic send, // Send-trigger command pulse
  input wire logic meas_trig, // Measurement trigger event
  input wire logic armed, // Ready-for-trigger level
  output logic pin_o, // Connector drive value
  output logic pin_oe, // Connector drive enable
  output logic done // User pulse finished, one cycle
);
  import trig_port_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PULSE = 2'b01,
    ST_EVENT = 2'b11
  } pstate_t;

  pstate_t state;
  pstate_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_pin_o;
  logic next_done;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        // A send during an active pulse never reaches here, so it is dropped
        if (cfg.dir_out && cfg.otype == OTYPE_USER && send) begin
          next_state = ST_PULSE;
          next_cnt = (pulse_len == '0) ? CNT_W'(1) : pulse_len; // Width in clock cycles
        end else if (cfg.dir_out && cfg.otype == OTYPE_DEVICE && meas_trig) begin
          next_state = ST_EVENT;
          next_cnt = CNT_W'(EVT_PULSE_CYC);
        end
      end
      ST_PULSE, ST_EVENT: begin
        // Hold the pulse for the loaded count, or end it early if the connector turns to input, then go idle
        if (cnt <= CNT_W'(1) || !cfg.dir_out) begin
          next_state = ST_IDLE;
          next_cnt = '0;
          next_done = (state == ST_PULSE);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
    // Output value per mode, registered so the pin never glitches
    case (cfg.otype)
      OTYPE_ARMED: next_pin_o = armed;
      OTYPE_USER: next_pin_o = (next_state == ST_PULSE) ? !cfg.idle_high : cfg.idle_high;
      default: next_pin_o = (next_state == ST_EVENT);
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      cnt <= '0;
      pin_o <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pin_o <= next_pin_o;
      done <= next_done;
    end
  end

  // Drive only in output direction
  assign pin_oe = cfg.dir_out;

  // ****************************************
  // Assertions
  // ****************************************
  property p_user_width;
    @(posedge clk) disable iff (!arst_n)
    (state == ST_IDLE && cfg.dir_out && cfg.otype == OTYPE_USER && send && pulse_len == CNT_W'(3))
    |=> (pin_o == !cfg.idle_high) [*3] ##1 (pin_o == cfg.idle_high);
  endproperty
  a_user_width: assert property (p_user_width) else $error("user pulse width wrong");

  property p_user_polarity;
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PULSE && cfg.otype == OTYPE_USER && cfg.dir_out) |-> (pin_o != cfg.idle_high);
  endproperty
  a_user_polarity: assert property (p_user_polarity) else $error("pulse polarity wrong");

  property p_armed_follow;
    @(posedge clk) disable iff (!arst_n)
    (cfg.otype == OTYPE_ARMED) ##1 (cfg.otype == OTYPE_ARMED) |-> pin_o == $past(armed);
  endproperty
  a_armed_follow: assert property (p_armed_follow) else $error("armed output wrong");

  property p_send_ignored;
    @(posedge clk) disable iff (!arst_n)
    (state == ST_PULSE && cnt > CNT_W'(1) && cfg.dir_out) |=> (cnt == $past(cnt) - CNT_W'(1));
  endproperty
  a_send_ignored: assert property (p_send_ignored) else $error("pulse restarted");

  property p_send_start;
    @(posedge clk) disable iff (!arst_n)
    (state == ST_IDLE && cfg.dir_out && cfg.otype == OTYPE_USER && send)
    |=> (state == ST_PULSE && pin_o == !cfg.idle_high);
  endproperty
  a_send_start: assert property (p_send_start) else $error("send did not start pulse");

  property p_event_pulse;
    @(posedge clk) disable iff (!arst_n)
    (state == ST_IDLE && cfg.dir_out && cfg.otype == OTYPE_DEVICE && meas_trig) |=> pin_o;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("no event pulse");

endmodule // trig_pulse_gen

// ### trig_port_ctrl.sv
// Top of the trigger connector and probe power control block
`timescale 1ns/100ps

module trig_port_ctrl #(
  parameter int NPORT = 2, // Configurable connectors
  parameter int CNT_W = 32 // Pulse counter width
) (
  input wire logic clk, // System clock, 250 MHz
  input wire logic arst_n, // Async reset, active low
  input wire trig_port_pkg::reg_req_t req, // Register access request
  output logic [31:0] rdata, // Read data, one cycle after read strobe
  input wire logic meas_trig, // Measurement trigger event pulse
  input wire logic armed, // Ready-for-trigger level
  input wire logic trig1_i, // Input-only connector level
  input wire logic [NPORT-1:0] trig_i, // Configurable connector levels
  output logic [NPORT-1:0] trig_o, // Configurable connector drive values
  output logic [NPORT-1:0] trig_oe, // Configurable connector drive enables
  output logic [NPORT:0] ext_trig, // External trigger sources, bit 0 = connector one
  output logic aux_ready_n, // Ready-for-trigger on aux line, active low
  output logic [1:0] probe_pwr_en, // Probe connector supply enables
  output logic irq // Level interrupt
);
  import trig_port_pkg::*;

  port_cfg_t cfg [NPORT];
  port_cfg_t next_cfg [NPORT];
  logic [CNT_W-1:0] pulse_len;
  logic [CNT_W-1:0] next_pulse_len;
  probe_sel_t probe_sel;
  probe_sel_t next_probe_sel;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] next_irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] next_irq_mask;
  logic [31:0] next_rdata;
  logic [NPORT-1:0] send;
  logic [NPORT-1:0] done;
  logic [IRQ_W-1:0] irq_set;
  logic aux_ready_n_q;

  // ****************************************
  // Register write and read decode
  // ****************************************
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      next_cfg[i] = cfg[i];
    end
    next_pulse_len = pulse_len;
    next_probe_sel = probe_sel;
    next_irq_mask = irq_mask;
    send = '0;
    next_rdata = 32'h0000_0000;
    irq_set = {meas_trig, done};
    // Set wins over a simultaneous write-one clear so no event is lost
    next_irq_status = irq_status;
    if (req.wr && req.addr == OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~req.wdata[IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_set;
    if (req.wr) begin
      case (req.addr)
        OFS_PORT_CFG: begin
          for (int i = 0; i < NPORT; i++) begin
            next_cfg[i].dir_out = req.wdata[i*CFG_FIELD_W + CFG_DIR_BIT];
            // Unused encoding falls back to event mode
            case (req.wdata[i*CFG_FIELD_W + CFG_TYPE_LSB +: 2])
              2'h1: next_cfg[i].otype = OTYPE_ARMED;
              2'h2: next_cfg[i].otype = OTYPE_USER;
              default: next_cfg[i].otype = OTYPE_DEVICE;
            endcase
            next_cfg[i].idle_high = req.wdata[i*CFG_FIELD_W + CFG_LEVEL_BIT];
          end
        end
        OFS_PULSE_LEN: next_pulse_len = req.wdata[CNT_W-1:0];
        OFS_COMMAND: send = req.wdata[NPORT-1:0]; // Self-clearing send bits
        OFS_PROBE_PWR: begin
          // Both-set encoding turns both supplies off, keeping at most one supply on
          case (req.wdata[PROBE_SEL_W-1:0])
            2'h1: next_probe_sel = PROBE_ONE;
            2'h2: next_probe_sel = PROBE_TWO;
            default: next_probe_sel = PROBE_OFF;
          endcase
        end
        OFS_IRQ_MASK: next_irq_mask = req.wdata[IRQ_W-1:0];
        default: begin
        end
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        OFS_PORT_CFG: begin
          for (int i = 0; i < NPORT; i++) begin
            next_rdata[i*CFG_FIELD_W +: CFG_FIELD_W] = {cfg[i].idle_high, cfg[i].otype,
                                                        cfg[i].dir_out};
          end
        end
        OFS_PULSE_LEN: next_rdata = 32'(pulse_len);
        OFS_PROBE_PWR: next_rdata = 32'(probe_sel);
        OFS_OPER_STATUS: next_rdata[OPER_ARMED_BIT] = armed;
        OFS_IRQ_STATUS: next_rdata = 32'(irq_status);
        OFS_IRQ_MASK: next_rdata = 32'(irq_mask);
        default: next_rdata = 32'h0000_0000; // Unmapped and command read as zero
      endcase
    end
  end

  // ****************************************
  // Register state
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NPORT; i++) begin
        cfg[i] <= '{dir_out: 1'b0, otype: OTYPE_DEVICE, idle_high: 1'b0};
      end
      pulse_len <= CNT_W'(PULSE_LEN_RST);
      probe_sel <= PROBE_OFF;
      irq_status <= '0;
      irq_mask <= '0;
      rdata <= 32'h0000_0000;
      aux_ready_n_q <= 1'b1;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        cfg[i] <= next_cfg[i];
      end
      pulse_len <= next_pulse_len;
      probe_sel <= next_probe_sel;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      rdata <= next_rdata;
      aux_ready_n_q <= !armed;
    end
  end

  // ****************************************
  // Connector drivers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      trig_pulse_gen #(.CNT_W(CNT_W)) u_gen (
        .clk(clk),
        .arst_n(arst_n),
        .cfg(cfg[g]),
        .pulse_len(pulse_len),
        .send(send[g]),
        .meas_trig(meas_trig),
        .armed(armed),
        .pin_o(trig_o[g]),
        .pin_oe(trig_oe[g]),
        .done(done[g])
      );
      // Input direction feeds the level to trigger logic; gated off when driving
      assign ext_trig[g+1] = trig_i[g] & !cfg[g].dir_out;
    end
  endgenerate

  // Connector one has no driver at all, only an input path
  assign ext_trig[0] = trig1_i;
  assign aux_ready_n = aux_ready_n_q;
  assign probe_pwr_en = {probe_sel == PROBE_TWO, probe_sel == PROBE_ONE};
  assign irq = |(irq_status & irq_mask);

  // ****************************************
  // Assertions
  // ****************************************
  property p_probe_onehot;
    @(posedge clk) disable iff (!arst_n)
    req.wr && req.addr == OFS_PROBE_PWR && req.wdata[1:0] == 2'h3 |=> probe_pwr_en == 2'b00;
  endproperty
  a_probe_onehot: assert property (p_probe_onehot) else $error("probe power not exclusive");

  property p_aux_ready;
    @(posedge clk) disable iff (!arst_n)
    1'b1 |=> aux_ready_n == !$past(armed);
  endproperty
  a_aux_ready: assert property (p_aux_ready) else $error("aux ready line wrong");

  property p_oper_bit;
    @(posedge clk) disable iff (!arst_n)
    req.rd && req.addr == OFS_OPER_STATUS |=> rdata[OPER_ARMED_BIT] == $past(armed);
  endproperty
  a_oper_bit: assert property (p_oper_bit) else $error("status bit 5 wrong");

  property p_input_path;
    @(posedge clk) disable iff (!arst_n)
    !cfg[0].dir_out |-> ext_trig[1] == trig_i[0] && !trig_oe[0];
  endproperty
  a_input_path: assert property (p_input_path) else $error("input direction wrong");

  property p_irq_set_wins;
    @(posedge clk) disable iff (!arst_n)
    meas_trig && req.wr && req.addr == OFS_IRQ_STATUS |=> irq_status[IRQ_MEAS_BIT];
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("event lost on clear");

  property p_drive_out;
    @(posedge clk) disable iff (!arst_n)
    cfg[0].dir_out && cfg[0].otype == OTYPE_DEVICE && meas_trig && !trig_o[0]
    |=> trig_oe[0] && trig_o[0];
  endproperty
  a_drive_out: assert property (p_drive_out) else $error("output not driven");

endmodule // trig_port_ctrl

// ### trig_equip_model.sv
// Model of the external test equipment that shares the two configurable trigger lines
`timescale 1ns/100ps
module trig_equip_model (
  input wire logic [1:0] pin_o, // Device drive values
  input wire logic [1:0] pin_oe, // Device drive enables
  input wire logic [1:0] level, // Level the equipment asserts
  output logic [1:0] line // Resolved connector levels
);
  // ****************************************
  // Line resolution
  // ****************************************
  // No pull on these lines, so the equipment always drives unless the device does
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      line[g] = pin_oe[g] ? pin_o[g] : level[g];
    end
  end
endmodule // trig_equip_model

// ### trig_port_ctrl_test.sv
// Self-checking testbench of the trigger connector control block
`timescale 1ns/100ps
module trig_port_ctrl_test;
  import trig_port_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  reg_req_t req = '0;
  logic meas_trig = 1'b0;
  logic armed = 1'b0;
  logic trig1_i = 1'b0;
  logic [1:0] lvl = 2'h0;
  logic [7:0] seed = 8'h3e;
  logic [31:0] rdata;
  logic [1:0] trig_i, trig_o, trig_oe, probe_pwr_en;
  logic [2:0] ext_trig;
  logic aux_ready_n, irq;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int sts = 0;
  int len;

  // ****************************************
  // Clock, design and partner
  // ****************************************
  always #2 clk = ~clk;

  trig_port_ctrl #(.NPORT(2), .CNT_W(32)) dut (.clk(clk), .arst_n(arst_n), .req(req),
    .rdata(rdata), .meas_trig(meas_trig), .armed(armed), .trig1_i(trig1_i), .trig_i(trig_i),
    .trig_o(trig_o), .trig_oe(trig_oe), .ext_trig(ext_trig), .aux_ready_n(aux_ready_n),
    .probe_pwr_en(probe_pwr_en), .irq(irq));

  trig_equip_model equip (.pin_o(trig_o), .pin_oe(trig_oe), .level(lvl), .line(trig_i));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic cmp_pin(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  // Bus write; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask

  // Bus read; data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    checked++;
    if (rdata !== exp) begin
      bad_count++;
      $display("mismatch at %0t: read %h got %h exp %h", $time, a, rdata, exp);
    end
  endtask

  // Pulse of n cycles then idle checks through cycle n+3 (four when n > 0); optional repeat send in mid-pulse
  // Entry is just after the edge that launched the pulse, so its first cycle is seen here
  task automatic pulse_chk(input int g, input logic idle, input int n, input logic resend);
    if (n > 0) begin
      cmp_pin(trig_o[g], !idle, "pulse start");
    end
    for (int k = 1; k <= n + 3; k++) begin
      @(posedge clk);
      req.wr <= resend && k == 1;
      #1;
      cmp_pin(trig_o[g], (k < n) ? !idle : idle, "trigger level");
    end
  endtask

  task automatic meas;
    @(posedge clk);
    meas_trig <= 1'b1;
    @(posedge clk);
    meas_trig <= 1'b0;
    sts = sts | 4;
    #1;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(OFS_PORT_CFG, 32'h0);
    rd(OFS_PULSE_LEN, PULSE_LEN_RST);
    rd(OFS_PROBE_PWR, 32'h0);
    rd(8'h1c, 32'h0);
    rd(OFS_COMMAND, 32'h0);
    wr(OFS_OPER_STATUS, 32'hffff_ffff);
    rd(OFS_OPER_STATUS, 32'h0);
    // Input direction: equipment levels reach the trigger sources
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      lvl <= seed[1:0];
      trig1_i <= seed[2];
      #1;
      cmp_pin(ext_trig[0], trig1_i, "connector one");
      cmp_pin(ext_trig[1], lvl[0], "front source");
      cmp_pin(ext_trig[2], lvl[1], "rear source");
      cmp_pin(trig_oe[0] | trig_oe[1], 1'b0, "enable in input");
    end
    // Event mode on the front connector
    // Type code three falls back to event mode
    wr(OFS_PORT_CFG, 32'h7);
    rd(OFS_PORT_CFG, 32'h1);
    cmp_pin(trig_oe[0], 1'b1, "front enable");
    meas();
    pulse_chk(0, 1'b0, EVT_PULSE_CYC, 1'b0);
    cmp_pin(ext_trig[1], 1'b0, "front source in output");
    rd(OFS_IRQ_STATUS, sts);
    // Clear of the event bit in the very cycle of a new event: the event must stay
    @(posedge clk);
    req.addr <= OFS_IRQ_STATUS;
    req.wdata <= 32'h4;
    req.wr <= 1'b1;
    meas_trig <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    meas_trig <= 1'b0;
    #1;
    rd(OFS_IRQ_STATUS, sts);
    cmp_pin(irq, 1'b0, "masked irq");
    // Armed mode on the rear connector, random ready level
    wr(OFS_PORT_CFG, 32'h30);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      #1;
      cmp_pin(trig_o[1], armed, "armed drive");
      cmp_pin(aux_ready_n, !armed, "aux ready");
      seed = lfsr(seed);
      armed <= seed[0];
    end
    armed <= 1'b1;
    rd(OFS_OPER_STATUS, 32'h20);
    armed <= 1'b0;
    rd(OFS_OPER_STATUS, 32'h0);
    // User mode: both idle levels on both connectors
    for (int idle = 0; idle < 2; idle++) begin
      for (int g = 0; g < 2; g++) begin
        seed = lfsr(seed);
        len = (idle == 0 && g == 0) ? 3 : 3 + seed % 6;
        wr(OFS_PULSE_LEN, len);
        wr(OFS_PORT_CFG, (idle[0] ? 32'hd : 32'h5) << (4 * g));
        pulse_chk(g, idle[0], 0, 1'b0);
        meas();
        pulse_chk(g, idle[0], 0, 1'b0);
        wr(OFS_COMMAND, 32'h1 << g);
        pulse_chk(g, idle[0], len, 1'b1);
        sts = sts | (1 << g);
        wr(OFS_IRQ_MASK, 32'h1 << g);
        cmp_pin(irq, 1'b1, "irq raised");
        rd(OFS_IRQ_STATUS, sts);
        wr(OFS_IRQ_STATUS, sts);
        sts = 0;
        cmp_pin(irq, 1'b0, "irq cleared");
      end
    end
    // A zero width still gives a one-cycle pulse
    wr(OFS_PULSE_LEN, 32'h0);
    wr(OFS_PORT_CFG, 32'h5);
    wr(OFS_COMMAND, 32'h1);
    pulse_chk(0, 1'b0, 1, 1'b0);
    // Probe power codes, the last one out of range
    for (int v = 0; v < 4; v++) begin
      wr(OFS_PROBE_PWR, v);
      cmp_pin(probe_pwr_en[0], v == 1, "probe one");
      cmp_pin(probe_pwr_en[1], v == 2, "probe two");
    end
    summarize();
  end
endmodule // trig_port_ctrl_test
